// File: hw/smsp_core.sv
// serial port core: registers, master shifter, slave shifter, flags
// assumes pins sampled synchronously; stop/wait levels come from the system
`timescale 1ns/1ns
// Function
// - irq when enabled and transfer done
// - enable bit turns port on
// - master bit chooses master or slave
// - idle master clock follows polarity bit
// - phase 0: select low starts transfer
// - phase 1: select enables output and clears count, first edge starts
// - rate bits divide clock, master only
// - done flag sets after each byte
// - done cleared by status read, data access
// - data writes ignored until status read
// - write during transfer sets collision outside stop, discarded
// - transfer window depends on phase
// - collision cleared by status read, data access
// - mode fault only when master selected low
// - mode fault drops enable and master
// - fault cleared by status read, control write
// - only master data write starts exchange
// - reads from receive buffer, overrun loses byte
// - data write goes straight to shifter
// - stop halts master clock generator
// - slave runs in stop, done flag deferred
// - wait mode leaves port active
// - most significant bit first
// - master gives eight pulses then idles
module smsp_core
  import smsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] regAddr,   // register offset
  input  wire logic [7:0] regWdata,  // write data
  input  wire logic       regWr,     // write strobe
  input  wire logic       regRd,     // read strobe
  output logic      [7:0] regRdata,  // read data, cycle after strobe
  input  wire logic       stopMode,  // system stop level
  input  wire logic       waitMode,  // system wait level, no effect
  input  wire logic       sckIn,     // serial clock pin input
  output logic            sckOut,
  output logic            sckOe_n,   // low while driving
  input  wire logic       mosiIn,
  output logic            mosiOut,
  output logic            mosiOe_n,
  input  wire logic       misoIn,
  output logic            misoOut,
  output logic            misoOe_n,
  input  wire logic       selIn_n,   // slave select pin
  output logic            irq        // interrupt request level
);
  typedef enum {ST_IDLE, ST_LEAD, ST_TRAIL} smsp_state_t;

  smsp_pins_t  pin;                  // sampled pin bundle
  smsp_state_t st_reg, st_next;      // master sequencer
  logic [7:0]  ctl_reg, ctl_next;    // control register
  logic [7:0]  shift_reg, shift_next; // shared shift register
  logic [7:0]  rxBuf_reg, rxBuf_next; // receive buffer
  logic [3:0]  bitCnt_reg, bitCnt_next;
  logic        done_reg, done_next, write_collision_flag_reg, write_collision_flag_next;
  logic        mode_fault_flag_reg, mode_fault_flag_next;
  logic        armed_reg, armed_next; // status read saw done set
  logic        seenDone_reg, seenDone_next;
  logic        seenWcol_reg, seenWcol_next, seenModf_reg, seenModf_next;
  logic        pendDone_reg, pendDone_next; // deferred done during stop
  logic        sckPrev_reg, sckPrev_next;
  logic        selPrev_reg, selPrev_next;
  logic        slvAct_reg, slvAct_next;   // slave transfer window
  logic        sckO_reg, sckO_next, mosiO_reg, mosiO_next, inBit_reg,
               inBit_next;
  logic [7:0]  rdata_next;
  logic        irq_next, halfTick;
  logic        enabled, isMaster, clock_idle_polarity, clock_phase_select, busy;
  logic        slvSample, slvShift, byteDone;

  assign pin.sck  = sckIn;
  assign pin.mosi = mosiIn;
  assign pin.miso = misoIn;
  assign pin.selN = selIn_n;

  assign enabled  = ctl_reg[CTL_SYS_EN];
  assign isMaster = ctl_reg[CTL_MASTER];
  assign clock_idle_polarity     = ctl_reg[CTL_CLOCK_IDLE_POLARITY];
  assign clock_phase_select     = ctl_reg[CTL_CLOCK_PHASE_SELECT];

  // rate generator halts in stop mode
  smsp_rate_gen u_rate (
    .clk      (clk),
    .arst_n   (arst_n),
    .run      (st_reg != ST_IDLE && !stopMode),
    .rateSel  ({ctl_reg[CTL_RATE_HI], ctl_reg[CTL_RATE_LO]}),
    .halfTick (halfTick)
  );

  // slave edge detection; the polarity bit acts as an inverter on sck
  logic sckLvl, sckLvlPrev, leadEdge, trailEdge;
  assign sckLvl     = pin.sck ^ clock_idle_polarity;
  assign sckLvlPrev = sckPrev_reg ^ clock_idle_polarity;
  assign leadEdge   = sckLvl & ~sckLvlPrev;
  assign trailEdge  = ~sckLvl & sckLvlPrev;
  // phase 0: shift clock is sck OR select, first edge samples
  // phase 1: first edge shifts out, second samples
  assign slvSample = !isMaster && enabled && !pin.selN && leadEdge;
  assign slvShift  = !isMaster && enabled && !pin.selN && trailEdge;
  assign busy = isMaster ? (st_reg != ST_IDLE) : slvAct_reg;

  // register, shifter and flag next-state logic
  always_comb begin
    ctl_next      = ctl_reg;
    shift_next    = shift_reg;
    rxBuf_next    = rxBuf_reg;
    bitCnt_next   = bitCnt_reg;
    done_next     = done_reg;
    write_collision_flag_next     = write_collision_flag_reg;
    mode_fault_flag_next     = mode_fault_flag_reg;
    armed_next    = armed_reg;
    seenDone_next = seenDone_reg;
    seenWcol_next = seenWcol_reg;
    seenModf_next = seenModf_reg;
    pendDone_next = pendDone_reg;
    st_next       = st_reg;
    sckO_next     = sckO_reg;
    mosiO_next    = mosiO_reg;
    inBit_next    = inBit_reg;
    slvAct_next   = slvAct_reg;
    sckPrev_next  = pin.sck;
    selPrev_next  = pin.selN;
    rdata_next    = BYTE_ZERO;
    byteDone      = 1'b0;

    // status read arms the clear sequence for flags seen set
    if (regRd && regAddr == ADDR_STATUS) begin
      seenDone_next = done_reg;
      seenWcol_next = write_collision_flag_reg;
      seenModf_next = mode_fault_flag_reg;
      armed_next    = done_reg;
    end
    // data access completes clears of done and collision
    if ((regRd || regWr) && regAddr == ADDR_DATA) begin
      if (seenDone_reg) begin
        done_next = 1'b0;
        seenDone_next = 1'b0;
      end
      if (seenWcol_reg) begin
        write_collision_flag_next = 1'b0;
        seenWcol_next = 1'b0;
      end
    end
    // control write; also completes a mode fault clear
    if (regWr && regAddr == ADDR_CONTROL) begin
      ctl_next = regWdata;
      if (seenModf_reg) begin
        mode_fault_flag_next = 1'b0;
        seenModf_next = 1'b0;
      end
    end
    // data write: ignored while done is set and unread
    if (regWr && regAddr == ADDR_DATA && (!done_reg || armed_reg)) begin
      if (busy) begin
        if (!stopMode) write_collision_flag_next = 1'b1;
      end else begin
        shift_next  = regWdata;
        bitCnt_next = 4'h0;
        if (isMaster && enabled) begin
          st_next    = ST_LEAD;
          mosiO_next = regWdata[7];
        end
      end
      armed_next = 1'b0;
    end

    // master sequencer: toggles sck on each half tick, eight pulses
    case (st_reg)
      ST_IDLE: begin
        sckO_next = clock_idle_polarity;
      end
      ST_LEAD: if (halfTick) begin
        sckO_next = ~sckO_reg;
        if (clock_phase_select) begin
          mosiO_next = shift_reg[7];
        end else begin
          inBit_next = pin.miso;
        end
        st_next = ST_TRAIL;
      end
      ST_TRAIL: if (halfTick) begin
        sckO_next = ~sckO_reg;
        shift_next = {shift_reg[6:0], clock_phase_select ? pin.miso : inBit_reg};
        // phase 1 moves mosi on the leading edge only, so the far side
        // still sees the current bit at this trailing edge
        if (!clock_phase_select) mosiO_next = shift_reg[6];
        bitCnt_next = bitCnt_reg + 4'h1;
        if (bitCnt_reg == BITS_PER_BYTE - 4'h1) begin
          st_next  = ST_IDLE;
          byteDone = 1'b1;
        end else begin
          st_next = ST_LEAD;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // master samples on trailing edge in clock_phase_select 1; sampling at trail time is fine,
    // data is taken from the line just before the shift

    // slave shifting
    if (!isMaster && enabled) begin
      if (!pin.selN && selPrev_reg) begin
        bitCnt_next = 4'h0;
        if (!clock_phase_select) slvAct_next = 1'b1;
      end
      if (slvSample) begin
        if (clock_phase_select) slvAct_next = 1'b1;
        inBit_next = pin.mosi;
        if (!clock_phase_select) begin
          shift_next  = {shift_reg[6:0], pin.mosi};
          bitCnt_next = bitCnt_reg + 4'h1;
          if (bitCnt_reg == BITS_PER_BYTE - 4'h1) byteDone = 1'b1;
        end
      end
      if (slvShift && clock_phase_select) begin
        shift_next  = {shift_reg[6:0], pin.mosi};
        bitCnt_next = bitCnt_reg + 4'h1;
        if (bitCnt_reg == BITS_PER_BYTE - 4'h1) begin
          byteDone = 1'b1;
          slvAct_next = 1'b0;
        end
      end
      if (pin.selN && !selPrev_reg && !clock_phase_select) slvAct_next = 1'b0;
    end

    // byte complete: buffer unless overrun, then flag
    if (byteDone) begin
      if (!done_reg) rxBuf_next = shift_next;
      if (stopMode) pendDone_next = 1'b1;
      else done_next = 1'b1;
    end
    if (!stopMode && pendDone_reg) begin
      done_next = 1'b1;
      pendDone_next = 1'b0;
    end

    // mode fault: master with select driven low
    if (isMaster && enabled && !pin.selN && !stopMode) begin
      mode_fault_flag_next = 1'b1;
      ctl_next[CTL_SYS_EN] = 1'b0;
      ctl_next[CTL_MASTER] = 1'b0;
      st_next = ST_IDLE;
    end

    // read mux, answered the cycle after the strobe
    if (regRd) begin
      case (regAddr)
        ADDR_CONTROL: rdata_next = ctl_reg;
        ADDR_STATUS: begin
          rdata_next[STS_DONE] = done_reg;
          rdata_next[STS_WRITE_COLLISION_FLAG] = write_collision_flag_reg;
          rdata_next[STS_MODE_FAULT_FLAG] = mode_fault_flag_reg;
        end
        ADDR_DATA: rdata_next = rxBuf_reg;
        default: rdata_next = BYTE_ZERO;
      endcase
    end
    irq_next = ctl_next[CTL_IRQ_EN] & (done_next | mode_fault_flag_next);
  end

  // register all state; data register is not reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_reg      <= CONTROL_RESET;
      done_reg     <= 1'b0;
      write_collision_flag_reg     <= 1'b0;
      mode_fault_flag_reg     <= 1'b0;
      armed_reg    <= 1'b0;
      seenDone_reg <= 1'b0;
      seenWcol_reg <= 1'b0;
      seenModf_reg <= 1'b0;
      pendDone_reg <= 1'b0;
      st_reg       <= ST_IDLE;
      bitCnt_reg   <= 4'h0;
      sckO_reg     <= 1'b0;
      mosiO_reg    <= 1'b0;
      inBit_reg    <= 1'b0;
      slvAct_reg   <= 1'b0;
      sckPrev_reg  <= 1'b0;
      selPrev_reg  <= 1'b1;
      regRdata     <= BYTE_ZERO;
      irq          <= 1'b0;
    end else begin
      ctl_reg      <= ctl_next;
      done_reg     <= done_next;
      write_collision_flag_reg     <= write_collision_flag_next;
      mode_fault_flag_reg     <= mode_fault_flag_next;
      armed_reg    <= armed_next;
      seenDone_reg <= seenDone_next;
      seenWcol_reg <= seenWcol_next;
      seenModf_reg <= seenModf_next;
      pendDone_reg <= pendDone_next;
      st_reg       <= st_next;
      bitCnt_reg   <= bitCnt_next;
      sckO_reg     <= sckO_next;
      mosiO_reg    <= mosiO_next;
      inBit_reg    <= inBit_next;
      slvAct_reg   <= slvAct_next;
      sckPrev_reg  <= sckPrev_next;
      selPrev_reg  <= selPrev_next;
      regRdata     <= rdata_next;
      irq          <= irq_next;
    end
  end

  // data storage has no reset value by design
  always_ff @(posedge clk) begin
    shift_reg <= shift_next;
    rxBuf_reg <= rxBuf_next;
  end

  // pin drivers: output enables low while driving
  logic sckOe_q, mosiOe_q, misoOe_q, misoO_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sckOe_q  <= 1'b1;
      mosiOe_q <= 1'b1;
      misoOe_q <= 1'b1;
      misoO_q  <= 1'b0;
    end else begin
      sckOe_q  <= ~(ctl_next[CTL_SYS_EN] & ctl_next[CTL_MASTER]);
      mosiOe_q <= ~(ctl_next[CTL_SYS_EN] & ctl_next[CTL_MASTER]);
      misoOe_q <= ~(ctl_next[CTL_SYS_EN] & ~ctl_next[CTL_MASTER]
                    & ~pin.selN);
      misoO_q  <= shift_next[7];
    end
  end
  assign sckOut   = sckO_reg;
  assign mosiOut  = mosiO_reg;
  assign misoOut  = misoO_q;
  assign sckOe_n  = sckOe_q;
  assign mosiOe_n = mosiOe_q;
  assign misoOe_n = misoOe_q;

  // check helper: serial clock toggles within the current master byte
  logic [4:0] pulseCnt_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulseCnt_reg <= 5'h00;
    end else if (st_reg == ST_IDLE) begin
      pulseCnt_reg <= 5'h00;
    end else if (sckO_next != sckO_reg) begin
      pulseCnt_reg <= pulseCnt_reg + 5'h01;
    end
  end

  // checks
  a_irq_follows_done: assert property (@(posedge clk) disable iff (!arst_n)
    done_reg && ctl_reg[CTL_IRQ_EN] |-> irq)
    else $error("irq missing with done set");
  a_idle_sck_pol: assert property (@(posedge clk) disable iff (!arst_n)
    st_reg == ST_IDLE && $past(st_reg) == ST_IDLE && $stable(clock_idle_polarity)
    |-> sckO_reg == clock_idle_polarity)
    else $error("idle clock level wrong");
  a_mode_fault_flag_drops_en: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(mode_fault_flag_reg) |-> !ctl_reg[CTL_SYS_EN] && !ctl_reg[CTL_MASTER])
    else $error("mode fault left port on");
  a_mode_fault_flag_only_master: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(mode_fault_flag_reg) |-> $past(isMaster) && !$past(pin.selN))
    else $error("mode fault without cause");
  a_write_collision_flag_keeps_shift: assert property (@(posedge clk) disable iff (!arst_n)
    regWr && regAddr == ADDR_DATA && busy && !slvShift && !slvSample
    && !(st_reg == ST_TRAIL && halfTick) |-> ##1 $stable(shift_reg))
    else $error("collision disturbed shifter");
  a_done_after_byte: assert property (@(posedge clk) disable iff (!arst_n)
    byteDone && !stopMode |-> ##1 done_reg)
    else $error("done not set after byte");
  a_stop_no_flag: assert property (@(posedge clk) disable iff (!arst_n)
    stopMode && !done_reg ##1 stopMode |-> !done_reg)
    else $error("flag set during stop");
  a_eight_pulses: assert property (@(posedge clk) disable iff (!arst_n)
    byteDone && isMaster
    |-> pulseCnt_reg == {BITS_PER_BYTE, 1'b0} - 5'h01)
    else $error("master byte length wrong");
  c_master_byte: cover property (@(posedge clk) byteDone && isMaster);
  c_slave_byte: cover property (@(posedge clk) byteDone && !isMaster);
  c_collision: cover property (@(posedge clk) $rose(write_collision_flag_reg));
  c_mode_fault: cover property (@(posedge clk) $rose(mode_fault_flag_reg));
endmodule

// File: hw/smsp_pkg.sv
// package for the byte-wide serial port: register map, fields, rates, types
// assumes a single 50 MHz clock domain and a plain strobe register port
package smsp_pkg;
  localparam logic [3:0] ADDR_CONTROL  = 4'h0; // control register offset
  localparam logic [3:0] ADDR_STATUS   = 4'h4; // status register offset
  localparam logic [3:0] ADDR_DATA     = 4'hC; // data register offset
  // control field positions
  localparam int CTL_IRQ_EN  = 7;
  localparam int CTL_SYS_EN  = 6;
  localparam int CTL_MASTER  = 4;
  localparam int CTL_CLOCK_IDLE_POLARITY    = 3;
  localparam int CTL_CLOCK_PHASE_SELECT    = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  // status field positions
  localparam int STS_DONE = 7;
  localparam int STS_WRITE_COLLISION_FLAG = 6;
  localparam int STS_MODE_FAULT_FLAG = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00; // port off, slave mode
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // half-period counts of the master clock, in system clocks, minus one
  localparam logic [3:0] HALF_DIV2  = 4'h0;
  localparam logic [3:0] HALF_DIV4  = 4'h1;
  localparam logic [3:0] HALF_DIV16 = 4'h7;
  localparam logic [3:0] HALF_DIV32 = 4'hF;
  // serial pin bundle seen by the core
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic selN;
  } smsp_pins_t;
endpackage

// File: hw/smsp_rate_gen.sv
// master rate generator: emits a one-cycle pulse every half serial period
// assumes run is low while idle or halted so the count restarts cleanly
`timescale 1ns/1ns
module smsp_rate_gen
  import smsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       run,      // count while high
  input  wire logic [1:0] rateSel,  // rate select pair
  output logic            halfTick  // one-cycle enable
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       tick_next;
  logic       tick_reg;

  // map rate code to half-period count
  function automatic logic [3:0] halfCount(input logic [1:0] sel);
    case (sel)
      2'h0:    halfCount = HALF_DIV2;
      2'h1:    halfCount = HALF_DIV4;
      2'h2:    halfCount = HALF_DIV16;
      default: halfCount = HALF_DIV32;
    endcase
  endfunction

  // next count; wraps at the selected half period
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = 4'h0;
    end else if (cnt_reg >= halfCount(rateSel)) begin
      cnt_next  = 4'h0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 4'h1;
    end
  end

  // register count and pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign halfTick = tick_reg & run;
endmodule

// File: tb/smsp_partner.sv
// far-side slave device model: shifts a byte each way, msb first
// assumes the bench owns select and the port drives sck and mosi
`timescale 1ns/1ns
module smsp_partner (
  input  wire logic       clk,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       selN,   // active-low select
  input  wire logic       clock_idle_polarity,
  input  wire logic       clock_phase_select,
  input  wire logic [7:0] txByte, // byte handed back
  output logic            miso,
  output logic      [7:0] rxByte  // byte received
);
  logic       sckQ   = 1'b0;  // sck seen at the last system clock
  logic [7:0] sh     = 8'h00; // outgoing shift
  logic       bitOut = 1'b0;  // bit presented on miso
  // released line has no pull: it shows the inverse of the last bit
  assign miso = selN ? ~bitOut : bitOut;
  // load on select falling; phase 0 shows the first bit at once
  always @(negedge selN) begin
    sh     = txByte;
    bitOut = txByte[7];
  end
  // shift edge follows the serial clock itself, so miso settles well
  // before the master samples it at its next system clock
  always @(sck) begin
    if (!selN && ((sck == clock_idle_polarity) ^ clock_phase_select)) begin
      bitOut = clock_phase_select ? sh[7] : sh[6];
      sh     = {sh[6:0], 1'b0};
    end
  end
  // sample edge, seen on the system clock
  always @(posedge clk) begin
    sckQ <= sck;
    if (!selN && sck != sckQ && ((sck != clock_idle_polarity) ^ clock_phase_select)) begin
      rxByte <= {rxByte[6:0], mosi};
    end
  end
endmodule

// File: tb/tb.sv
// self-checking bench for the serial port core
// assumes one 50 MHz clock; the bench is cpu, select and slave-side master
`timescale 1ns/1ns
module tb;
  import smsp_pkg::*;
  localparam logic [7:0] DONE = 8'h1 << STS_DONE;
  localparam logic [7:0] WRITE_COLLISION_FLAG = 8'h1 << STS_WRITE_COLLISION_FLAG;
  localparam logic [7:0] MODE_FAULT_FLAG = 8'h1 << STS_MODE_FAULT_FLAG;
  logic        clk, arst_n, regWr, regRd, stopMode, waitMode;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata;
  logic        sckOut, sckOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n, irq;
  logic        selIn_n, tbSck, tbMosi, partSel_n, partMiso, clock_idle_polarity, clock_phase_select;
  logic        sckW, mosiW, misoW, sckQ;
  logic [7:0]  partTx, partRx, rd, tx, got;
  logic [31:0] lfsr;
  int          n_fail, total_checks, tog, gap, minGap, maxGap, t0;
  int          halves[4] = '{1, 2, 8, 16}; // divide 2, 4, 16, 32 halved
  // wire levels: whoever enables wins, the bench fills in otherwise
  assign sckW  = !sckOe_n ? sckOut : tbSck;
  assign mosiW = !mosiOe_n ? mosiOut : tbMosi;
  assign misoW = !misoOe_n ? misoOut : partMiso;
  smsp_core u_smsp_core (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .stopMode(stopMode), .waitMode(waitMode),
    .sckIn(sckW), .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiIn(mosiW),
    .mosiOut(mosiOut), .mosiOe_n(mosiOe_n), .misoIn(misoW),
    .misoOut(misoOut), .misoOe_n(misoOe_n), .selIn_n(selIn_n), .irq(irq));
  smsp_partner u_smsp_partner (.clk(clk), .sck(sckW), .mosi(mosiW),
    .selN(partSel_n), .clock_idle_polarity(clock_idle_polarity), .clock_phase_select(clock_phase_select), .txByte(partTx),
    .miso(partMiso), .rxByte(partRx));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // counts master clock toggles and the gap between them
  always @(posedge clk) begin
    sckQ <= sckOut;
    gap  <= gap + 1;
    if (sckOut !== sckQ) begin
      tog <= tog + 1;
      gap <= 1;
      if (tog > 0 && gap < minGap) begin
        minGap <= gap;
      end
      if (tog > 0 && gap > maxGap) begin
        maxGap <= gap;
      end
    end
  end
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdReg(input logic [3:0] a);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  // bounded wait on the interrupt level
  task automatic waitIrq(input logic lvl);
    for (int i = 0; i < 3000 && irq !== lvl; i++) @(posedge clk);
    if (irq !== lvl) begin
      n_fail++;
      $display("Error at %0t: wait on irq ran out", $time);
      report_and_stop();
    end
    // one more edge so the toggle monitor has settled its counts
    @(posedge clk);
  endtask
  // reselect the partner with a fresh byte, then load the shifter
  task automatic byteOut(input logic [7:0] b);
    lfsr = nextRand(lfsr);
    @(posedge clk);
    partSel_n <= 1'b1;
    partTx    <= lfsr[15:8];
    @(posedge clk);
    partSel_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 tog = 0;
    minGap = 99;
    maxGap = 0;
    wr(ADDR_DATA, b);
  endtask
  // one full master byte in a given mode, model against design
  task automatic xfer(input logic [7:0] ctl, input int hp);
    wr(ADDR_CONTROL, ctl);
    @(posedge clk);
    clock_idle_polarity <= ctl[CTL_CLOCK_IDLE_POLARITY];
    clock_phase_select <= ctl[CTL_CLOCK_PHASE_SELECT];
    rdReg(ADDR_CONTROL);
    chk(rd, ctl);
    chk({7'h0, sckOut}, {7'h0, ctl[CTL_CLOCK_IDLE_POLARITY]});
    chk({7'h0, sckOe_n}, 8'h00);
    lfsr = nextRand(lfsr);
    tx = lfsr[7:0];
    byteOut(tx);
    waitIrq(1'b1);
    chk(8'(tog), 8'd16);
    chk(8'(minGap), 8'(hp));
    chk(8'(maxGap), 8'(hp));
    chk({7'h0, sckOut}, {7'h0, ctl[CTL_CLOCK_IDLE_POLARITY]});
    chk(partRx, tx);
    rdReg(ADDR_STATUS);
    chk(rd, DONE);
    rdReg(ADDR_DATA);
    chk(rd, partTx);
    rdReg(ADDR_STATUS);
    chk(rd, BYTE_ZERO);
  endtask
  initial begin
    {arst_n, regWr, regRd, stopMode, waitMode, tbSck, tbMosi} = '0;
    {regAddr, regWdata, partTx, clock_idle_polarity, clock_phase_select} = '0;
    {selIn_n, partSel_n} = 2'b11;
    lfsr = 32'h044942FA;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rdReg(ADDR_CONTROL);
    chk(rd, CONTROL_RESET);
    rdReg(ADDR_STATUS);
    chk(rd, BYTE_ZERO);
    chk({7'h0, sckOe_n}, 8'h01);
    // unmapped write must not land in control
    wr(4'h8, 8'hFF);
    rdReg(ADDR_CONTROL);
    chk(rd, CONTROL_RESET);
    $display("test reset finished");
    // each rate once, each with a different one of the four clock modes; wait level on for one of them
    for (int i = 0; i < 4; i++) begin
      waitMode <= (i == 2);
      xfer({4'hD, i[0], i[1], i[1], i[0]}, halves[i]);
    end
    waitMode <= 1'b0;
    $display("test modes and rates finished");
    // done still set: a data write is ignored until status is read
    lfsr = nextRand(lfsr);
    byteOut(lfsr[7:0]);
    waitIrq(1'b1);
    @(posedge clk);
    #1 tog = 0;
    wr(ADDR_DATA, 8'h5A);
    repeat (40) @(posedge clk);
    chk(8'(tog), 8'h00);
    rdReg(ADDR_STATUS);
    chk(rd, DONE);
    // write now clears done and starts; a second write collides
    tx = ~lfsr[7:0];
    byteOut(tx);
    repeat (40) @(posedge clk);
    wr(ADDR_DATA, ~tx);
    stopMode <= 1'b1;
    repeat (4) @(posedge clk);
    #1 t0 = tog;
    repeat (60) @(posedge clk);
    chk(8'(tog - t0), 8'h00);
    stopMode <= 1'b0;
    waitIrq(1'b1);
    chk(8'(tog), 8'd16);
    chk(partRx, tx);
    rdReg(ADDR_STATUS);
    chk(rd, DONE | WRITE_COLLISION_FLAG);
    rdReg(ADDR_DATA);
    chk(rd, partTx);
    rdReg(ADDR_STATUS);
    chk(rd, BYTE_ZERO);
    partSel_n <= 1'b1;
    $display("test ignore collision stop finished");
    // a master whose select is pulled low faults and steps down
    wr(ADDR_CONTROL, 8'hD0);
    selIn_n <= 1'b0;
    repeat (3) @(posedge clk);
    selIn_n <= 1'b1;
    waitIrq(1'b1);
    rdReg(ADDR_STATUS);
    chk(rd, MODE_FAULT_FLAG);
    rdReg(ADDR_CONTROL);
    chk(rd, 8'h80);
    wr(ADDR_CONTROL, 8'h80);
    rdReg(ADDR_STATUS);
    chk(rd, BYTE_ZERO);
    waitIrq(1'b0);
    $display("test mode fault finished");
    // slave, phase 1, rate bits set: the bench is the master
    wr(ADDR_CONTROL, 8'hC7);
    lfsr = nextRand(lfsr);
    tx = lfsr[7:0];
    wr(ADDR_DATA, tx);
    repeat (20) @(posedge clk);
    chk({7'h0, sckOe_n}, 8'h01);
    selIn_n <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      repeat (6) @(posedge clk);
      tbSck  <= 1'b1;
      tbMosi <= lfsr[8 + b];
      repeat (6) @(posedge clk);
      tbSck <= 1'b0;
      got   = {got[6:0], misoW};
    end
    repeat (6) @(posedge clk);
    selIn_n <= 1'b1;
    waitIrq(1'b1);
    chk(got, tx);
    rdReg(ADDR_STATUS);
    chk(rd, DONE);
    rdReg(ADDR_DATA);
    chk(rd, lfsr[15:8]);
    $display("test slave finished");
    report_and_stop();
  end
endmodule
